//--- common/sac_pkg.sv
package sac_pkg;
  // Clock rates and derived timing counts.
  localparam int SYS_CLK_HZ = 200_000_000;
  localparam int CPU_CLK_HZ = 8_000_000;
  localparam int CPU_DIV = SYS_CLK_HZ / CPU_CLK_HZ;
  localparam int CONV_CPU_CYCLES = 64;
  // The sampling window is 31.5 CPU cycles, held here as 63 half cycles.
  localparam int SAMPLE_CPU_HALVES = 63;
  localparam int CONV_CYCLES = CONV_CPU_CYCLES * CPU_DIV;
  localparam int SAMPLE_CYCLES = (SAMPLE_CPU_HALVES * CPU_DIV + 1) / 2;
  localparam int RESULT_BITS = 8;
  localparam int BITS_CYCLES = CONV_CYCLES - SAMPLE_CYCLES;
  localparam int STEP_CYCLES = BITS_CYCLES / RESULT_BITS;
  localparam int SETTLE_NS = 30_000;
  localparam int SETTLE_CYCLES = (SETTLE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CNT_W = 16;

  // Register map: printed offsets are indices, the byte address is four times the index.
  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;
  localparam logic [9:0] IDX_RESULT = 10'h070;
  localparam logic [9:0] IDX_CSR = 10'h071;
  localparam logic [9:0] IDX_STATUS = 10'h072;
  localparam logic [9:0] IDX_MASK = 10'h073;
  localparam logic [AXI_ADDR_W-1:0] ADDR_RESULT = {IDX_RESULT, 2'b00};
  localparam logic [AXI_ADDR_W-1:0] ADDR_CSR = {IDX_CSR, 2'b00};
  localparam logic [AXI_ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [AXI_ADDR_W-1:0] ADDR_MASK = {IDX_MASK, 2'b00};
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Control/status field layout and reset values.
  localparam int CSR_FLAG_BIT = 7;
  localparam int CSR_POWER_BIT = 5;
  localparam int CSR_ZERO_BIT = 4;
  localparam int CSR_CHAN_LSB = 0;
  localparam int CSR_CHAN_W = 3;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] TRIAL_FIRST = 8'h80;

  // Interrupt status and mask layout.
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_SETTLE_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  typedef enum logic [2:0] {SEL_RESULT, SEL_CSR, SEL_STATUS, SEL_MASK, SEL_NONE} sac_sel_t;
  typedef enum logic [1:0] {ST_OFF, ST_SETTLE, ST_SAMPLE, ST_BITS} sac_state_t;
endpackage : sac_pkg

//--- hw/sac_sar_step.sv
`timescale 1ns/1ps
module sac_sar_step (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Sequencer control
  input wire logic start_in,
  input wire logic decide_in,
  input wire logic comp_in,
  // Trial code and result
  output logic busy_out,
  output logic [7:0] trial_out,
  output logic [7:0] result_out
);
  logic [2:0] bit_q;
  logic [7:0] trial_q;
  logic [7:0] result_q;
  logic busy_q;
  logic [7:0] bit_mask;
  logic [7:0] code_d;

  assign bit_mask = 8'h01 << bit_q;
  // A high comparator means the input stands at or above the trial level, so the bit stays.
  assign code_d = comp_in ? trial_q : (trial_q & ~bit_mask);

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bit_q <= 3'h7;
      trial_q <= sac_pkg::RESULT_RESET;
      result_q <= sac_pkg::RESULT_RESET;
      busy_q <= 1'b0;
    end else if (start_in) begin
      bit_q <= 3'h7;
      trial_q <= sac_pkg::TRIAL_FIRST;
      busy_q <= 1'b1;
    end else if (decide_in && busy_q) begin
      if (bit_q != 3'h0) begin
        trial_q <= code_d | (bit_mask >> 1);
        bit_q <= bit_q - 3'h1;
      end else begin
        trial_q <= code_d;
        result_q <= code_d;
        busy_q <= 1'b0;
      end
    end
  end

  assign busy_out = busy_q;
  assign trial_out = trial_q;
  assign result_out = result_q;
endmodule : sac_sar_step

//--- hw/sac_top.sv
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// - Finished result lands in 8-bit readable register.
// - Input at or above top gives FFh.
// - Input at or below bottom gives 00h.
// - Conversion 64 CPU cycles, 31.5 sampling.
// - Result scales linearly across reference span.
// - Low three bits select one of eight inputs.
// - Power on, settle, then convert continuously.
// - Completion sets flag bit 7, updates result.
// - Control write aborts, clears flag, restarts.
// - Reading result clears the completion flag.
// - Power bit zero stops all conversions.
// - Bit 4 always reads as zero.
// - Wait mode leaves conversion running.
// - Halt disables; wake-up needs settling again.
// - Reset clears control and result to zero.
module sac_top #(
  parameter int SETTLE_CYCLES = sac_pkg::SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // AXI4-Lite write channels
  input wire logic [sac_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [sac_pkg::AXI_DATA_W-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read channels
  input wire logic [sac_pkg::AXI_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [sac_pkg::AXI_DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Converter core and processor mode
  input wire logic comparator_in,
  input wire logic halt_in,
  output logic converter_power_on_out,
  output logic [2:0] input_channel_select_out,
  output logic sample_hold_out,
  output logic [7:0] trial_code_out,
  // Interrupt
  output logic irq_out
);
  localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYCLES - 1);
  localparam logic [15:0] SAMPLE_LAST = 16'(sac_pkg::SAMPLE_CYCLES - 1);
  localparam logic [15:0] BITS_LAST = 16'(sac_pkg::BITS_CYCLES - 1);
  localparam logic [15:0] STEP_LAST = 16'(sac_pkg::STEP_CYCLES - 1);
  localparam logic [15:0] CONV_LAST = 16'(sac_pkg::CONV_CYCLES - 1);
  localparam logic [15:0] SAMPLE_LEN = 16'(sac_pkg::SAMPLE_CYCLES);

  function automatic sac_pkg::sac_sel_t decode_sel(input logic [sac_pkg::AXI_ADDR_W-1:0] a);
    case (a)
      sac_pkg::ADDR_RESULT: decode_sel = sac_pkg::SEL_RESULT;
      sac_pkg::ADDR_CSR: decode_sel = sac_pkg::SEL_CSR;
      sac_pkg::ADDR_STATUS: decode_sel = sac_pkg::SEL_STATUS;
      sac_pkg::ADDR_MASK: decode_sel = sac_pkg::SEL_MASK;
      default: decode_sel = sac_pkg::SEL_NONE;
    endcase
  endfunction : decode_sel

  // Reset release and pin synchronisers.
  logic rst_meta_q;
  logic rst_n;
  logic comp_meta_q;
  logic comp_sync_q;
  logic halt_meta_q;
  logic halt_sync_q;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      comp_meta_q <= 1'b0;
      comp_sync_q <= 1'b0;
      halt_meta_q <= 1'b0;
      halt_sync_q <= 1'b0;
    end else begin
      comp_meta_q <= comparator_in;
      comp_sync_q <= comp_meta_q;
      halt_meta_q <= halt_in;
      halt_sync_q <= halt_meta_q;
    end
  end

  // Register bus slave.
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic aw_got_q;
  logic w_got_q;
  logic [sac_pkg::AXI_ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wlane0_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [sac_pkg::AXI_DATA_W-1:0] rdata_q;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_go;
  sac_pkg::sac_sel_t wr_sel;
  sac_pkg::sac_sel_t rd_sel;
  logic csr_wr;
  logic result_rd;

  assign aw_hs = s_axi_awvalid_in && awready_q;
  assign w_hs = s_axi_wvalid_in && wready_q;
  assign ar_hs = s_axi_arvalid_in && arready_q;
  assign wr_go = aw_got_q && w_got_q && !bvalid_q;
  assign wr_sel = decode_sel(awaddr_q);
  assign rd_sel = decode_sel(s_axi_araddr_in);
  assign csr_wr = wr_go && wlane0_q && (wr_sel == sac_pkg::SEL_CSR);
  assign result_rd = ar_hs && (rd_sel == sac_pkg::SEL_RESULT);

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wlane0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= sac_pkg::RESP_OKAY;
    end else begin
      awready_q <= !aw_got_q && !aw_hs && !wr_go && !bvalid_q;
      wready_q <= !w_got_q && !w_hs && !wr_go && !bvalid_q;
      if (aw_hs) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
      end
      if (w_hs) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata_in[7:0];
        wlane0_q <= s_axi_wstrb_in[0];
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_sel == sac_pkg::SEL_NONE) ? sac_pkg::RESP_DECERR : sac_pkg::RESP_OKAY;
      end else if (bvalid_q && s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Control/status, result and interrupt registers.
  logic [7:0] result_q;
  logic flag_q;
  logic power_q;
  logic [2:0] chan_q;
  logic [sac_pkg::IRQ_W-1:0] irq_stat_q;
  logic [sac_pkg::IRQ_W-1:0] irq_mask_q;
  logic irq_q;
  logic done_evt;
  logic settle_evt;
  logic [7:0] sar_result;
  logic [7:0] csr_view;
  logic [sac_pkg::IRQ_W-1:0] irq_evt;
  logic [sac_pkg::IRQ_W-1:0] irq_w1c;

  always_comb begin
    csr_view = 8'h00;
    csr_view[sac_pkg::CSR_FLAG_BIT] = flag_q;
    csr_view[sac_pkg::CSR_POWER_BIT] = power_q;
    csr_view[sac_pkg::CSR_CHAN_LSB +: sac_pkg::CSR_CHAN_W] = chan_q;
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      power_q <= sac_pkg::CSR_RESET[sac_pkg::CSR_POWER_BIT];
      chan_q <= sac_pkg::CSR_RESET[sac_pkg::CSR_CHAN_LSB +: sac_pkg::CSR_CHAN_W];
      irq_mask_q <= sac_pkg::IRQ_RESET;
    end else if (wr_go && wlane0_q) begin
      if (wr_sel == sac_pkg::SEL_CSR) begin
        power_q <= wdata_q[sac_pkg::CSR_POWER_BIT];
        chan_q <= wdata_q[sac_pkg::CSR_CHAN_LSB +: sac_pkg::CSR_CHAN_W];
      end
      if (wr_sel == sac_pkg::SEL_MASK) begin
        irq_mask_q <= wdata_q[sac_pkg::IRQ_W-1:0];
      end
    end
  end

  // A completion in the same cycle as a clearing access keeps the flag set.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= sac_pkg::CSR_RESET[sac_pkg::CSR_FLAG_BIT];
      result_q <= sac_pkg::RESULT_RESET;
    end else if (done_evt) begin
      flag_q <= 1'b1;
      result_q <= sar_result;
    end else if (csr_wr || result_rd) begin
      flag_q <= 1'b0;
    end
  end

  assign irq_evt = {settle_evt, done_evt};
  assign irq_w1c = (wr_go && wlane0_q && wr_sel == sac_pkg::SEL_STATUS) ?
                   wdata_q[sac_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= sac_pkg::IRQ_RESET;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_w1c) | irq_evt;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= sac_pkg::RESP_OKAY;
      rdata_q <= '0;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= (rd_sel == sac_pkg::SEL_NONE) ? sac_pkg::RESP_DECERR : sac_pkg::RESP_OKAY;
      case (rd_sel)
        sac_pkg::SEL_RESULT: rdata_q <= {24'h00_0000, result_q};
        sac_pkg::SEL_CSR: rdata_q <= {24'h00_0000, csr_view};
        sac_pkg::SEL_STATUS: rdata_q <= {30'h0000_0000, irq_stat_q};
        sac_pkg::SEL_MASK: rdata_q <= {30'h0000_0000, irq_mask_q};
        default: rdata_q <= '0;
      endcase
    end else if (rvalid_q) begin
      if (s_axi_rready_in) begin
        rvalid_q <= 1'b0;
      end
    end else begin
      arready_q <= 1'b1;
    end
  end

  // Conversion sequencer. Wait mode has no input here, so it cannot disturb it.
  sac_pkg::sac_state_t st_q;
  sac_pkg::sac_state_t st_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] step_q;
  logic restart_q;
  logic enabled;
  logic sar_start;
  logic sar_decide;
  logic sar_busy;
  logic [7:0] sar_trial;
  logic sample_q;
  logic conv_power_q;

  assign enabled = power_q && !halt_sync_q;

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= csr_wr;
    end
  end

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 16'h0001;
    sar_start = 1'b0;
    done_evt = 1'b0;
    settle_evt = 1'b0;
    if (!enabled) begin
      st_d = sac_pkg::ST_OFF;
      cnt_d = 16'h0000;
    end else begin
      case (st_q)
        sac_pkg::ST_OFF: begin
          st_d = sac_pkg::ST_SETTLE;
          cnt_d = 16'h0000;
        end
        sac_pkg::ST_SETTLE: begin
          if (cnt_q == SETTLE_LAST) begin
            st_d = sac_pkg::ST_SAMPLE;
            cnt_d = 16'h0000;
            settle_evt = 1'b1;
          end
        end
        sac_pkg::ST_SAMPLE: begin
          if (restart_q) begin
            cnt_d = 16'h0000;
          end else if (cnt_q == SAMPLE_LAST) begin
            st_d = sac_pkg::ST_BITS;
            cnt_d = 16'h0000;
            sar_start = 1'b1;
          end
        end
        sac_pkg::ST_BITS: begin
          if (restart_q) begin
            st_d = sac_pkg::ST_SAMPLE;
            cnt_d = 16'h0000;
          end else if (cnt_q == BITS_LAST) begin
            st_d = sac_pkg::ST_SAMPLE;
            cnt_d = 16'h0000;
            done_evt = 1'b1;
          end
        end
        default: begin
          st_d = sac_pkg::ST_OFF;
          cnt_d = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= sac_pkg::ST_OFF;
      cnt_q <= 16'h0000;
      sample_q <= 1'b0;
      conv_power_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sample_q <= (st_d == sac_pkg::ST_SAMPLE);
      conv_power_q <= enabled;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= 16'h0000;
    end else if (sar_start || step_q == STEP_LAST) begin
      step_q <= 16'h0000;
    end else begin
      step_q <= step_q + 16'h0001;
    end
  end

  assign sar_decide = (st_q == sac_pkg::ST_BITS) && !restart_q && (step_q == STEP_LAST);

  sac_sar_step u_sar (
    .clock_in(clock_in),
    .reset_n_in(rst_n),
    .start_in(sar_start),
    .decide_in(sar_decide),
    .comp_in(comp_sync_q),
    .busy_out(sar_busy),
    .trial_out(sar_trial),
    .result_out(sar_result)
  );

  // Binary-weighted trial code drives the core's linear reference ladder.
  assign trial_code_out = sar_trial;
  assign converter_power_on_out = conv_power_q;
  assign input_channel_select_out = chan_q;
  assign sample_hold_out = sample_q;
  assign irq_out = irq_q;
  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out = wready_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rresp_out = rresp_q;
  assign s_axi_rdata_out = rdata_q;

  // Cycles since the current conversion entered sampling.
  logic [15:0] age_q;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      age_q <= 16'h0000;
    end else if (st_d == sac_pkg::ST_SAMPLE && cnt_d == 16'h0000) begin
      age_q <= 16'h0000;
    end else if (age_q != 16'hFFFF) begin
      age_q <= age_q + 16'h0001;
    end
  end

  conv_period_a: assert property (
    @(posedge clock_in) disable iff (!rst_n) done_evt |-> age_q == CONV_LAST)
    else $error("conversion did not last the full period");

  sample_len_a: assert property (
    @(posedge clock_in) disable iff (!rst_n) $fell(sample_q) && enabled |-> age_q == SAMPLE_LEN)
    else $error("sampling window has the wrong length");

  flag_result_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    done_evt |=> flag_q && result_q == $past(sar_result))
    else $error("completion did not set flag and result");

  write_abort_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    csr_wr && !done_evt |=> !flag_q ##1 (!enabled || (st_q == sac_pkg::ST_SAMPLE && cnt_q == 16'h0000)) ||
      st_q == sac_pkg::ST_SETTLE)
    else $error("control write did not abort and restart");

  read_clear_a: assert property (
    @(posedge clock_in) disable iff (!rst_n) result_rd && !done_evt |=> !flag_q)
    else $error("result read did not clear the flag");

  off_idle_a: assert property (
    @(posedge clock_in) disable iff (!rst_n) !power_q |=> !sample_q && !done_evt && !conv_power_q)
    else $error("converter active while powered off");

  csr_zero_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    ar_hs && rd_sel == sac_pkg::SEL_CSR |=> rdata_q[sac_pkg::CSR_ZERO_BIT] == 1'b0)
    else $error("reserved control bit read as one");

  halt_settle_a: assert property (
    @(posedge clock_in) disable iff (!rst_n)
    $fell(halt_sync_q) && power_q |=> st_q == sac_pkg::ST_SETTLE)
    else $error("wake-up skipped the settling delay");

  sar_order_a: assert property (
    @(posedge clock_in) disable iff (!rst_n) sar_start |=> sar_trial == sac_pkg::TRIAL_FIRST)
    else $error("approximation did not begin at the top bit");
endmodule : sac_top

//--- bench/sac_analog_model.sv
`timescale 1ns/1ps
module sac_analog_model (
  // Clock
  input wire logic clock_in,
  // Converter controls from the block
  input wire logic power_in,
  input wire logic [2:0] channel_in,
  input wire logic hold_in,
  input wire logic [7:0] trial_in,
  // Analog levels and comparator
  input wire logic [7:0] level_in [8],
  output logic comparator_out
);
  logic [7:0] held_q = 8'h00;
  logic idle_q = 1'b0;
  // The hold capacitor tracks the selected input only while sampling.
  always_ff @(posedge clock_in) begin
    if (hold_in) begin
      held_q <= level_in[channel_in];
    end
    idle_q <= ~idle_q;
  end
  // An unpowered core gives no decision, so the pin shows a changing level.
  assign comparator_out = power_in ? (held_q >= trial_in) : idle_q;
endmodule : sac_analog_model

//--- bench/sac_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sac_top_tb;
  localparam int SETTLE = 20;
  localparam logic [1:0] OK = sac_pkg::RESP_OKAY;
  localparam logic [1:0] DEC = sac_pkg::RESP_DECERR;
  localparam logic [11:0] NOWHERE = 12'h1D0;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic awvalid = 0, awready, wvalid = 0, wready, bready = 0, bvalid;
  logic arvalid = 0, arready, rready = 0, rvalid, comparator, halt = 0;
  logic [1:0] bresp, rresp;
  logic power, sample_hold, irq;
  logic [2:0] chan;
  logic [7:0] trial;
  logic [7:0] lv [8] = '{8'h00, 8'h7F, 8'h80, 8'h01, 8'hFE, 8'h55, 8'hAA, 8'hFF};
  int fails = 0, checked = 0, cyc = 0, rise_at = 0, per = 0, hi_cnt = 0, hi_len = 0;

  sac_top #(.SETTLE_CYCLES(SETTLE)) i_dut (
    .clock_in(clock_in), .reset_n_in(reset_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .comparator_in(comparator),
    .halt_in(halt), .converter_power_on_out(power), .input_channel_select_out(chan),
    .sample_hold_out(sample_hold), .trial_code_out(trial), .irq_out(irq)
  );
  sac_analog_model i_model (
    .clock_in(clock_in), .power_in(power), .channel_in(chan), .hold_in(sample_hold),
    .trial_in(trial), .level_in(lv), .comparator_out(comparator)
  );

  always #2.5 clock_in = ~clock_in;

  // Measures the sampling window length and the rise-to-rise period.
  always @(posedge clock_in) begin
    cyc++;
    if (sample_hold === 1'b1) begin
      hi_cnt++;
    end else if (hi_cnt != 0) begin
      hi_len = hi_cnt;
      hi_cnt = 0;
    end
    if (sample_hold === 1'b1 && hi_cnt == 1) begin
      per = cyc - rise_at;
      rise_at = cyc;
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock_in);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100) fails++;
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    if (n >= 100) fails++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    `CHK(d & m, e)
    `CHK(r, er)
  endtask : rd_chk

  task automatic wait_flag();
    int n;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    d = '0;
    while (d[7] !== 1'b1 && n < 2000) begin
      axi_rd(sac_pkg::ADDR_CSR, d, r);
      n++;
    end
    `CHK(d[7], 1'b1)
  endtask : wait_flag

  task automatic wait_hold(input logic v, output int n);
    n = 0;
    while (sample_hold !== v && n < 3000) begin
      @(posedge clock_in);
      n++;
    end
  endtask : wait_hold

  task automatic test_reset();
    `CHK({power, sample_hold, irq}, 3'b000)
    rd_chk(sac_pkg::ADDR_RESULT, 32'hFFFF_FFFF, 32'h0000_0000, OK);
    rd_chk(sac_pkg::ADDR_CSR, 32'hFFFF_FFFF, 32'h0000_0000, OK);
    rd_chk(sac_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 32'h0000_0000, OK);
    rd_chk(sac_pkg::ADDR_MASK, 32'hFFFF_FFFF, 32'h0000_0000, OK);
    rd_chk(NOWHERE, 32'hFFFF_FFFF, 32'h0000_0000, DEC);
    axi_wr(NOWHERE, 32'h0000_0025, 4'h1, DEC);
    axi_wr(sac_pkg::ADDR_RESULT, 32'h0000_00FF, 4'h1, OK);
    rd_chk(sac_pkg::ADDR_RESULT, 32'hFFFF_FFFF, 32'h0000_0000, OK);
  endtask : test_reset

  task automatic test_channels();
    for (int c = 0; c < 8; c++) begin
      axi_wr(sac_pkg::ADDR_CSR, 32'h0000_0020 | 32'(c), 4'h1, OK);
      // The power output follows the control bit one cycle after the write lands.
      @(posedge clock_in);
      `CHK(chan, c[2:0])
      `CHK(power, 1'b1)
      wait_flag();
      rd_chk(sac_pkg::ADDR_RESULT, 32'hFFFF_FFFF, {24'h0, lv[c]}, OK);
      rd_chk(sac_pkg::ADDR_CSR, 32'h0000_0080, 32'h0000_0000, OK);
    end
  endtask : test_channels

  task automatic test_timing();
    repeat (2 * sac_pkg::CONV_CYCLES + 100) @(posedge clock_in);
    `CHK(per, sac_pkg::CONV_CYCLES)
    `CHK(hi_len, sac_pkg::SAMPLE_CYCLES)
  endtask : test_timing

  task automatic test_abort();
    int n;
    wait_flag();
    wait_hold(1'b0, n);
    repeat (200) @(posedge clock_in);
    axi_wr(sac_pkg::ADDR_CSR, 32'h0000_0025, 4'h1, OK);
    repeat (3) @(posedge clock_in);
    `CHK(sample_hold, 1'b1)
    rd_chk(sac_pkg::ADDR_CSR, 32'h0000_0080, 32'h0000_0000, OK);
    wait_flag();
    rd_chk(sac_pkg::ADDR_RESULT, 32'hFFFF_FFFF, {24'h0, lv[5]}, OK);
  endtask : test_abort

  task automatic test_halt();
    int n;
    halt <= 1'b1;
    repeat (6) @(posedge clock_in);
    `CHK({power, sample_hold}, 2'b00)
    halt <= 1'b0;
    wait_hold(1'b1, n);
    `CHK(n >= SETTLE && n <= SETTLE + 10, 1'b1)
  endtask : test_halt

  task automatic test_irq();
    axi_wr(sac_pkg::ADDR_CSR, 32'h0000_0021, 4'h1, OK);
    axi_wr(sac_pkg::ADDR_STATUS, 32'h0000_0003, 4'h1, OK);
    axi_wr(sac_pkg::ADDR_MASK, 32'h0000_0001, 4'h0, OK);
    rd_chk(sac_pkg::ADDR_MASK, 32'hFFFF_FFFF, 32'h0000_0000, OK);
    axi_wr(sac_pkg::ADDR_MASK, 32'h0000_0001, 4'h1, OK);
    repeat (2) @(posedge clock_in);
    `CHK(irq, 1'b0)
    wait_flag();
    repeat (2) @(posedge clock_in);
    `CHK(irq, 1'b1)
    axi_wr(sac_pkg::ADDR_STATUS, 32'h0000_0001, 4'h1, OK);
    repeat (2) @(posedge clock_in);
    `CHK(irq, 1'b0)
    axi_wr(sac_pkg::ADDR_MASK, 32'h0000_0000, 4'h1, OK);
    axi_wr(sac_pkg::ADDR_CSR, 32'h0000_0021, 4'h1, OK);
    wait_flag();
    repeat (2) @(posedge clock_in);
    `CHK(irq, 1'b0)
    rd_chk(sac_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0001, OK);
  endtask : test_irq

  task automatic test_off();
    int n;
    axi_wr(sac_pkg::ADDR_CSR, 32'h0000_0017, 4'h1, OK);
    rd_chk(sac_pkg::ADDR_CSR, 32'hFFFF_FFFF, 32'h0000_0007, OK);
    wait_hold(1'b1, n);
    `CHK(n, 3000)
    `CHK(power, 1'b0)
    rd_chk(sac_pkg::ADDR_CSR, 32'h0000_0080, 32'h0000_0000, OK);
    axi_wr(sac_pkg::ADDR_CSR, 32'h0000_0037, 4'h1, OK);
    rd_chk(sac_pkg::ADDR_CSR, 32'hFFFF_FFFF, 32'h0000_0027, OK);
  endtask : test_off

  initial begin
    repeat (60_000) @(posedge clock_in);
    fails++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    test_reset();
    test_channels();
    test_timing();
    test_abort();
    test_halt();
    test_irq();
    test_off();
    wrap_up();
  end
endmodule : sac_top_tb
